// ===== hw/pin_function_mux.sv
/*
 * Low-power pin function mux: selector registers on a plain register
 * port, and per-pin routing of eight function slots plus a 64-entry
 * wide function matrix for the general pins 0..3.
 * Assumes peripherals present per-pin slot drives on REF_CLK_I and pad
 * inputs arrive asynchronously.
 */
// Implementation choice: strobed register access.
//
// Behaviour
// RL1 - 3-bit selector picks slot; 1 means matrix (only on general pins 0..3; on flash pins and pin 24 code 1 is plain slot 1)
// RL2 - Flash pins 4..0 at bits 18:16..2:0
// RL3 - Software uses recommended flash pin codes
// RL4 - Software keeps flash pins off other functions
// RL5 - Pin 24 selector in bits 2:0 only
// RL6 - Matrix register: four 6-bit fields, reset 3F3F3F3F
// RL7 - Matrix code acts only while selector is 1
// RL8 - Unused bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none

module pin_function_mux (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // Register port
   input wire logic [31:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   // Function slot sources and sinks, per pin
   input wire logic [pinfn_pkg::NUM_PINS-1:0][pinfn_pkg::NUM_SLOTS-1:0]
      SLOT_DO_I,
   input wire logic [pinfn_pkg::NUM_PINS-1:0][pinfn_pkg::NUM_SLOTS-1:0]
      SLOT_OE_I,
   output logic [pinfn_pkg::NUM_PINS-1:0][pinfn_pkg::NUM_SLOTS-1:0]
      SLOT_DI_O,
   // Wide function matrix sources and sinks
   input wire logic [pinfn_pkg::NUM_WIDE-1:0] WIDE_DO_I,
   input wire logic [pinfn_pkg::NUM_WIDE-1:0] WIDE_OE_I,
   output logic [pinfn_pkg::NUM_WIDE-1:0] WIDE_DI_O,
   // Pads
   input wire logic [pinfn_pkg::NUM_PINS-1:0] PIN_IN_I,
   output pinfn_pkg::pin_drive_s [pinfn_pkg::NUM_PINS-1:0] PIN_O
);

   import pinfn_pkg::*;

   // ************************************
   // Declarations
   // ************************************
   logic [31:0] flash_sel_r;
   logic [31:0] pin24_sel_r;
   logic [31:0] wide_mtx_r;
   logic [31:0] gen_sel_r;
   logic [31:0] rdata_nxt;
   logic [NUM_PINS-1:0] pin_in_sync;
   sel_t [NUM_PINS-1:0] sel;
   wide_t [NUM_PINS-1:0] code;
   pin_drive_s [NUM_PINS-1:0] drive_nxt;
   logic [NUM_PINS-1:0][NUM_SLOTS-1:0] slot_en;
   logic [NUM_PINS-1:0][NUM_WIDE-1:0] wide_en;
   logic [NUM_WIDE-1:0] wide_di_nxt;
   logic wr_flash, wr_pin24, wr_wide, wr_gen;

   // ************************************
   // Pad input synchroniser
   // ************************************
   pin_sync #(
      .WIDTH(NUM_PINS)
   ) pin_sync_inst (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .async_i(PIN_IN_I),
      .sync_o(pin_in_sync)
   );

   // ************************************
   // Register writes
   // ************************************
   assign wr_flash = REG_WR_I && (REG_ADDR_I == ADDR_FLASH_SEL);
   assign wr_pin24 = REG_WR_I && (REG_ADDR_I == ADDR_PIN24_SEL);
   assign wr_wide = REG_WR_I && (REG_ADDR_I == ADDR_WIDE_MTX0);
   assign wr_gen = REG_WR_I && (REG_ADDR_I == ADDR_GEN_SEL);

   // Storing only the field bits keeps unused bits at zero for good
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         flash_sel_r <= RST_FLASH_SEL;
      end else if (wr_flash) begin
         flash_sel_r <= REG_WDATA_I & MASK_FLASH_SEL; // RL2 RL8
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         pin24_sel_r <= RST_PIN24_SEL;
      end else if (wr_pin24) begin
         pin24_sel_r <= REG_WDATA_I & MASK_PIN24_SEL; // RL5 RL8
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         wide_mtx_r <= RST_WIDE_MTX0; // RL6
      end else if (wr_wide) begin
         wide_mtx_r <= REG_WDATA_I & MASK_WIDE_MTX0; // RL6 RL8
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         gen_sel_r <= RST_GEN_SEL;
      end else if (wr_gen) begin
         gen_sel_r <= REG_WDATA_I & MASK_GEN_SEL; // RL8
      end
   end

   // ************************************
   // Register reads
   // ************************************
   // Unmapped addresses read as zero; data stands one cycle only
   always_comb begin
      case (REG_ADDR_I)
         ADDR_FLASH_SEL: rdata_nxt = flash_sel_r;
         ADDR_PIN24_SEL: rdata_nxt = pin24_sel_r;
         ADDR_WIDE_MTX0: rdata_nxt = wide_mtx_r;
         ADDR_GEN_SEL: rdata_nxt = gen_sel_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         REG_RDATA_O <= 32'h0000_0000;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= rdata_nxt; // RL8
      end else begin
         REG_RDATA_O <= 32'h0000_0000;
      end
   end

   // ************************************
   // Field extraction
   // ************************************
   genvar gf;
   generate
      for (gf = 0; gf < NUM_FLASH; gf++) begin : g_flash
         assign sel[PIN_FLASH0+gf] =
            flash_sel_r[gf*SEL_STRIDE +: SEL_W]; // RL2
         assign code[PIN_FLASH0+gf] = '0;
      end
      for (gf = 0; gf < NUM_GEN; gf++) begin : g_gen
         assign sel[PIN_GEN0+gf] = gen_sel_r[gf*SEL_STRIDE +: SEL_W];
         assign code[PIN_GEN0+gf] =
            wide_mtx_r[gf*WIDE_STRIDE +: WIDE_W]; // RL6
      end
   endgenerate
   assign sel[PIN_24] = pin24_sel_r[SEL_W-1:0]; // RL5
   assign code[PIN_24] = '0;

   // ************************************
   // Per-pin routing
   // ************************************
   // Only the general pins own a matrix field; elsewhere slot 1 is a
   // plain function slot
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
         fn_slot_select fn_slot_select_inst (
            .sel_i(sel[gp]), // RL1
            .code_i(code[gp]),
            .wide_ok_i(gp >= PIN_GEN0), // RL7
            .slot_do_i(SLOT_DO_I[gp]),
            .slot_oe_i(SLOT_OE_I[gp]),
            .wide_do_i(WIDE_DO_I),
            .wide_oe_i(WIDE_OE_I),
            .drive_o(drive_nxt[gp]),
            .slot_en_o(slot_en[gp]),
            .wide_en_o(wide_en[gp])
         );

         always_ff @(posedge REF_CLK_I) begin
            if (RST_I) begin
               PIN_O[gp] <= '0;
               SLOT_DI_O[gp] <= '0;
            end else begin
               PIN_O[gp] <= drive_nxt[gp]; // RL1
               SLOT_DI_O[gp] <= slot_en[gp] &
                  {NUM_SLOTS{pin_in_sync[gp]}}; // RL1
            end
         end
      end
   endgenerate

   // Two pins on one matrix code both feed it; their inputs are ORed
   always_comb begin
      wide_di_nxt = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         wide_di_nxt = wide_di_nxt |
            (wide_en[i] & {NUM_WIDE{pin_in_sync[i]}}); // RL7
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         WIDE_DI_O <= '0;
      end else begin
         WIDE_DI_O <= wide_di_nxt;
      end
   end

   // ************************************
   // Checks
   // ************************************
   pin_drive_s p24_expect;
   pin_drive_s gen0_slot_expect;
   pin_drive_s gen0_wide_expect;
   assign p24_expect = {SLOT_DO_I[PIN_24][sel[PIN_24]],
                        SLOT_OE_I[PIN_24][sel[PIN_24]]};
   assign gen0_slot_expect = {SLOT_DO_I[PIN_GEN0][sel[PIN_GEN0]],
                              SLOT_OE_I[PIN_GEN0][sel[PIN_GEN0]]};
   assign gen0_wide_expect = {WIDE_DO_I[code[PIN_GEN0]],
                              WIDE_OE_I[code[PIN_GEN0]]};

   slot_route_a: assert property ( // RL1
      @(posedge REF_CLK_I) disable iff (RST_I)
      1'h1 |=> PIN_O[PIN_24] == $past(p24_expect))
      else $error("pin 24 drive does not follow its slot");

   flash_field_a: assert property ( // RL2
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_flash ##1 (REG_RD_I && REG_ADDR_I == ADDR_FLASH_SEL)
      |=> REG_RDATA_O[18:16] == $past(REG_WDATA_I[18:16], 2) &&
          REG_RDATA_O[2:0] == $past(REG_WDATA_I[2:0], 2))
      else $error("flash selector field not read back");

   pin24_field_a: assert property ( // RL5
      @(posedge REF_CLK_I) disable iff (RST_I)
      (REG_RD_I && REG_ADDR_I == ADDR_PIN24_SEL)
      |=> REG_RDATA_O == {29'h0, sel[PIN_24]} ||
          $past(wr_pin24, 1))
      else $error("pin 24 selector read back wrong");

   matrix_reset_a: assert property ( // RL6
      @(posedge REF_CLK_I)
      $fell(RST_I) |-> wide_mtx_r == 32'h3F3F_3F3F &&
                       code[PIN_GEN0+3] == 6'h3F)
      else $error("matrix register reset value wrong");

   wide_take_a: assert property ( // RL7
      @(posedge REF_CLK_I) disable iff (RST_I)
      sel[PIN_GEN0] == 3'h1 |=> PIN_O[PIN_GEN0] == $past(gen0_wide_expect))
      else $error("matrix code ignored while selector is 1");

   wide_ignore_a: assert property ( // RL7
      @(posedge REF_CLK_I) disable iff (RST_I)
      sel[PIN_GEN0] != 3'h1
      |=> PIN_O[PIN_GEN0] == $past(gen0_slot_expect) &&
          $past(wide_en[PIN_GEN0]) == '0)
      else $error("matrix code acted while selector not 1");

   unused_zero_a: assert property ( // RL8
      @(posedge REF_CLK_I) disable iff (RST_I)
      REG_RD_I |=> (REG_RDATA_O & ~MASK_FLASH_SEL & ~MASK_WIDE_MTX0) == '0)
      else $error("unused register bits read non-zero");

   read_once_a: assert property ( // RL8
      @(posedge REF_CLK_I) disable iff (RST_I)
      !REG_RD_I |=> REG_RDATA_O == 32'h0000_0000)
      else $error("read data stands outside its cycle");

   flash0_route_a: assert property ( // RL2
      @(posedge REF_CLK_I) disable iff (RST_I)
      1'h1 |=> PIN_O[PIN_FLASH0] ==
         $past({SLOT_DO_I[PIN_FLASH0][flash_sel_r[2:0]],
                SLOT_OE_I[PIN_FLASH0][flash_sel_r[2:0]]}))
      else $error("flash pin 0 drive does not follow bits 2:0");

   flash4_route_a: assert property ( // RL2
      @(posedge REF_CLK_I) disable iff (RST_I)
      1'h1 |=> PIN_O[PIN_FLASH0+4] ==
         $past({SLOT_DO_I[PIN_FLASH0+4][flash_sel_r[18:16]],
                SLOT_OE_I[PIN_FLASH0+4][flash_sel_r[18:16]]}))
      else $error("flash pin 4 drive does not follow bits 18:16");

   slot_in_a: assert property ( // RL1
      @(posedge REF_CLK_I) disable iff (RST_I)
      1'h1 |=> SLOT_DI_O[PIN_24] ==
         $past(pin_in_sync[PIN_24] ? 8'h01 << sel[PIN_24] : 8'h00))
      else $error("pin 24 input not routed to its slot");

   wide_quiet_a: assert property ( // RL7
      @(posedge REF_CLK_I) disable iff (RST_I)
      sel[PIN_GEN0] != 3'h1 && sel[PIN_GEN0+1] != 3'h1 &&
      sel[PIN_GEN0+2] != 3'h1 && sel[PIN_GEN0+3] != 3'h1
      |=> WIDE_DI_O == '0)
      else $error("matrix input fed while no pin selects it");

   unmapped_keep_a: assert property ( // RL8
      @(posedge REF_CLK_I) disable iff (RST_I)
      REG_WR_I && !wr_flash && !wr_pin24 && !wr_wide && !wr_gen
      |=> $stable(flash_sel_r) && $stable(pin24_sel_r) &&
          $stable(wide_mtx_r) && $stable(gen_sel_r))
      else $error("write to unmapped address changed a register");

   matrix_read_a: assert property ( // RL6
      @(posedge REF_CLK_I) disable iff (RST_I)
      (REG_RD_I && REG_ADDR_I == ADDR_WIDE_MTX0)
      |=> REG_RDATA_O[29:24] == $past(code[PIN_GEN0+3]) &&
          REG_RDATA_O[5:0] == $past(code[PIN_GEN0]))
      else $error("matrix fields read back at wrong bits");

endmodule // pin_function_mux

`default_nettype wire

// ===== shared/pinfn_pkg.sv
/*
 * Constants, types and register map of the low-power pin function mux.
 * Assumes a single clock domain and a plain register port with byte
 * addresses; every printed offset is word aligned.
 */
`default_nettype none

package pinfn_pkg;

   // ************************************
   // Sizes
   // ************************************
   localparam int NUM_PINS = 10;
   localparam int NUM_FLASH = 5;
   localparam int NUM_GEN = 4;
   localparam int NUM_SLOTS = 8;
   localparam int NUM_WIDE = 64;
   localparam int SEL_W = 3;
   localparam int WIDE_W = 6;

   // Pin order on the pin ports
   localparam int PIN_FLASH0 = 0;
   localparam int PIN_24 = 5;
   localparam int PIN_GEN0 = 6;

   // ************************************
   // Register map
   // ************************************
   localparam logic [31:0] ADDR_FLASH_SEL = 32'h4000_B068;
   localparam logic [31:0] ADDR_PIN24_SEL = 32'h4000_B080;
   localparam logic [31:0] ADDR_WIDE_MTX0 = 32'h4000_B1A0;
   localparam logic [31:0] ADDR_GEN_SEL = 32'h4000_B1F0;

   // Field layout: primary selectors every 4 bits, matrix every 8 bits
   localparam int SEL_STRIDE = 4;
   localparam int WIDE_STRIDE = 8;

   localparam logic [31:0] RST_FLASH_SEL = 32'h0000_0000;
   localparam logic [31:0] RST_PIN24_SEL = 32'h0000_0000;
   localparam logic [31:0] RST_WIDE_MTX0 = 32'h3F3F_3F3F;
   localparam logic [31:0] RST_GEN_SEL = 32'h0000_0000;

   localparam logic [31:0] MASK_FLASH_SEL = 32'h0007_7777;
   localparam logic [31:0] MASK_PIN24_SEL = 32'h0000_0007;
   localparam logic [31:0] MASK_WIDE_MTX0 = 32'h3F3F_3F3F;
   localparam logic [31:0] MASK_GEN_SEL = 32'h0000_7777;

   // Primary selector code that hands a pin to the matrix
   localparam logic [2:0] SEL_WIDE = 3'h1;

   // ************************************
   // Types
   // ************************************
   typedef logic [SEL_W-1:0] sel_t;
   typedef logic [WIDE_W-1:0] wide_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_s;

endpackage

`default_nettype wire

// ===== hw/pin_sync.sv
/*
 * Two-stage synchroniser for pad inputs.
 * Assumes the inputs are asynchronous to REF_CLK_I.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   generate
      if (WIDTH < 1) begin : g_width_check
         $error("pin_sync: WIDTH must be at least 1");
      end
   endgenerate

   // First stage feeds the second stage only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule // pin_sync

`default_nettype wire

// ===== hw/fn_slot_select.sv
/*
 * Per-pin function selection: picks the driving slot, or the matrix
 * function when the pin supports the matrix and its selector is 1.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
`default_nettype none

module fn_slot_select (
   // Selection
   input wire pinfn_pkg::sel_t sel_i,
   input wire pinfn_pkg::wide_t code_i,
   input wire logic wide_ok_i,
   // Function sources
   input wire logic [pinfn_pkg::NUM_SLOTS-1:0] slot_do_i,
   input wire logic [pinfn_pkg::NUM_SLOTS-1:0] slot_oe_i,
   input wire logic [pinfn_pkg::NUM_WIDE-1:0] wide_do_i,
   input wire logic [pinfn_pkg::NUM_WIDE-1:0] wide_oe_i,
   // Results
   output pinfn_pkg::pin_drive_s drive_o,
   output logic [pinfn_pkg::NUM_SLOTS-1:0] slot_en_o,
   output logic [pinfn_pkg::NUM_WIDE-1:0] wide_en_o
);

   import pinfn_pkg::*;

   logic use_wide;

   always_comb begin
      use_wide = wide_ok_i && (sel_i == SEL_WIDE);
      if (use_wide) begin
         drive_o.out = wide_do_i[code_i];
         drive_o.oe = wide_oe_i[code_i];
         slot_en_o = '0;
         wide_en_o = NUM_WIDE'(1) << code_i;
      end else begin
         drive_o.out = slot_do_i[sel_i];
         drive_o.oe = slot_oe_i[sel_i];
         slot_en_o = NUM_SLOTS'(1) << sel_i;
         wide_en_o = '0;
      end
   end

endmodule // fn_slot_select

`default_nettype wire

// ===== tb/pin_function_mux_test.sv
/*
 * Self-checking testbench of the low-power pin function mux.
 * Assumes the design and its package are compiled first and that the
 * register port answers a read in the cycle after the strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_function_mux_test;
   import pinfn_pkg::*;

   // ************************************
   // Stimulus and observed signals
   // ************************************
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [31:0] reg_addr = 32'h0000_0000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic [NUM_PINS-1:0][NUM_SLOTS-1:0] slot_do = '0;
   logic [NUM_PINS-1:0][NUM_SLOTS-1:0] slot_oe = '0;
   logic [NUM_PINS-1:0][NUM_SLOTS-1:0] slot_di;
   logic [NUM_WIDE-1:0] wide_do = '0;
   logic [NUM_WIDE-1:0] wide_oe = '0;
   logic [NUM_WIDE-1:0] wide_di;
   logic [NUM_PINS-1:0] pin_in = '0;
   pin_drive_s [NUM_PINS-1:0] pin_o;
   int n_errors = 0;
   int n_compared = 0;
   logic [31:0] map_addr [4] = '{ADDR_FLASH_SEL, ADDR_PIN24_SEL,
      ADDR_WIDE_MTX0, ADDR_GEN_SEL};
   logic [31:0] map_rst [4] = '{RST_FLASH_SEL, RST_PIN24_SEL,
      RST_WIDE_MTX0, RST_GEN_SEL};
   logic [31:0] map_mask [4] = '{MASK_FLASH_SEL, MASK_PIN24_SEL,
      MASK_WIDE_MTX0, MASK_GEN_SEL};

   always #50 ref_clk = ~ref_clk;

   pin_function_mux pin_function_mux_inst (
      .REF_CLK_I(ref_clk),
      .RST_I(rst),
      .REG_ADDR_I(reg_addr),
      .REG_WDATA_I(reg_wdata),
      .REG_WR_I(reg_wr),
      .REG_RD_I(reg_rd),
      .REG_RDATA_O(reg_rdata),
      .SLOT_DO_I(slot_do),
      .SLOT_OE_I(slot_oe),
      .SLOT_DI_O(slot_di),
      .WIDE_DO_I(wide_do),
      .WIDE_OE_I(wide_oe),
      .WIDE_DI_O(wide_di),
      .PIN_IN_I(pin_in),
      .PIN_O(pin_o)
   );

   // ************************************
   // Shared tasks
   // ************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic end_sim;
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Called at a rising edge; the strobe stays up at return so that a
   // further access may follow with no gap
   task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      reg_rd <= 1'h0;
      @(posedge ref_clk);
   endtask

   // Data stands only in the cycle after the strobe; taken at its end
   task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      @(posedge ref_clk);
      d = reg_rdata;
   endtask

   // Ends any access, then covers selector delay and the pad flops
   task automatic settle;
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      repeat (4) @(posedge ref_clk);
   endtask

   // ************************************
   // Scenarios
   // ************************************
   task automatic t_regs;
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         reg_read(map_addr[i], d);
         chk(d, map_rst[i]);
         reg_write(map_addr[i], 32'hFFFF_FFFF);
         reg_read(map_addr[i], d);
         chk(d, map_mask[i]);
      end
      @(posedge ref_clk);
      chk(reg_rdata, 32'h0000_0000);
      reg_write(32'h4000_B1A4, 32'hFFFF_FFFF);
      reg_read(32'h4000_B1A4, d);
      chk(d, 32'h0000_0000);
   endtask

   // Every code on pin 24, including code 1 as a plain slot there
   task automatic t_pin24;
      @(posedge ref_clk);
      slot_do[PIN_24] <= 8'hA5;
      slot_oe[PIN_24] <= 8'h3C;
      pin_in[PIN_24] <= 1'h1;
      for (int c = 0; c < 8; c++) begin
         reg_write(ADDR_PIN24_SEL, 32'(c) | 32'hFFFF_FFF8);
         settle();
         chk(pin_o[PIN_24], {slot_do[PIN_24][c], slot_oe[PIN_24][c]});
         chk(slot_di[PIN_24], 8'h01 << c);
      end
   endtask

   // Recommended flash codes, each pin sees only its own slot high
   task automatic t_flash;
      int codes [5];
      codes = '{1, 3, 2, 4, 0};
      @(posedge ref_clk);
      for (int i = 0; i < NUM_FLASH; i++) begin
         slot_do[PIN_FLASH0+i] <= 8'h01 << codes[i];
         slot_oe[PIN_FLASH0+i] <= ~(8'h01 << codes[i]);
      end
      reg_write(ADDR_FLASH_SEL, 32'h0000_4231);
      settle();
      for (int i = 0; i < NUM_FLASH; i++) begin
         chk(pin_o[PIN_FLASH0+i], 2'h2);
      end
   endtask

   task automatic t_wide;
      @(posedge ref_clk);
      slot_do[PIN_GEN0] <= 8'h00;
      slot_do[PIN_GEN0+1] <= 8'h00;
      slot_oe[PIN_GEN0] <= 8'h00;
      slot_oe[PIN_GEN0+1] <= 8'h00;
      wide_do <= 64'h0000_0000_0000_0020;
      wide_oe <= 64'h0000_0000_0000_0200;
      pin_in[PIN_GEN0] <= 1'h1;
      pin_in[PIN_GEN0+1] <= 1'h1;
      reg_write(ADDR_GEN_SEL, 32'h0000_0000);
      reg_write(ADDR_WIDE_MTX0, 32'h3F3F_0905);
      settle();
      chk(pin_o[PIN_GEN0], 2'h0);
      chk(wide_di, 64'h0000_0000_0000_0000);
      reg_write(ADDR_GEN_SEL, 32'h0000_0011);
      settle();
      chk(pin_o[PIN_GEN0], 2'h2);
      chk(pin_o[PIN_GEN0+1], 2'h1);
      chk(wide_di, 64'h0000_0000_0000_0220);
   endtask

   // A reset in mid-run must bring back the matrix reset codes
   task automatic t_reset;
      logic [31:0] d;
      reg_write(ADDR_WIDE_MTX0, 32'h0000_0000);
      reg_wr <= 1'h0;
      rst <= 1'h1;
      @(posedge ref_clk);
      rst <= 1'h0;
      @(posedge ref_clk);
      chk(pin_o, '0);
      reg_read(ADDR_WIDE_MTX0, d);
      chk(d, RST_WIDE_MTX0);
   endtask

   // ************************************
   // Main sequence and watchdog
   // ************************************
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      chk(pin_o, '0);
      t_regs();
      t_pin24();
      t_flash();
      t_wide();
      t_reset();
      end_sim();
   end

   // The run needs under a hundred cycles; this is ample margin
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end

endmodule // pin_function_mux_test

`default_nettype wire
